//--- sdf_pkg.sv
// Shared constants and types for the sinc3 decimation filter
package sdf_pkg;
  // Modulator rate is the master clock divided by this count
  localparam int unsigned MOD_DIV = 128;
  localparam logic [6:0] MOD_LAST = 7'h7f;
  // Filter select word
  localparam int unsigned FSEL_W = 12;
  localparam logic [11:0] FSEL_RST = 12'h100;
  localparam logic [11:0] FSEL_ONE = 12'h001;
  // Accumulator holds N^3 for N up to 4095, plus sign
  localparam int unsigned ACC_W = 38;
  // Output word, full scale at 2^22 so there is one bit of headroom below the sign bit
  localparam int unsigned OUT_W = 24;
  localparam int unsigned FS_SHIFT = 22;
  localparam int unsigned NUM_W = ACC_W + FS_SHIFT;
  // Words discarded after a restart before output resumes
  localparam logic [1:0] SETTLE_LAST = 2'h2;
  // Register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_FILT = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_DATA = 8'h0c;
  // Field positions
  localparam int unsigned CTRL_RESTART_BIT = 0;
  localparam int unsigned CTRL_CHAN_LSB = 4;
  localparam int unsigned CHAN_W = 3;
  localparam logic [2:0] CHAN_RST = 3'h0;
  localparam int unsigned STAT_READY_BIT = 0;
  localparam int unsigned STAT_SETTLED_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 2;
  localparam int unsigned STAT_WCNT_LSB = 4;

  typedef enum logic [1:0] {
    SDF_ST_CLEAR = 2'b00,
    SDF_ST_FILL = 2'b01,
    SDF_ST_RUN = 2'b11
  } sdf_state_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } sdf_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } sdf_wb_rsp_s;
endpackage

//--- sdf_cic.sv
// Three integrators at the modulator rate and three combs at the word rate
`timescale 1ns/100ps
`default_nettype none
module sdf_cic #(
  parameter int unsigned W = sdf_pkg::ACC_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic smp,
  input wire logic bit_in,
  input wire logic dec,
  output logic [W-1:0] y,
  output logic y_vld
);
  import sdf_pkg::*;

  typedef struct packed {
    logic [W-1:0] i1;
    logic [W-1:0] i2;
    logic [W-1:0] i3;
    logic [W-1:0] d1;
    logic [W-1:0] d2;
    logic [W-1:0] d3;
    logic [W-1:0] y;
    logic dec_d;
    logic vld;
  } sdf_cic_s;

  sdf_cic_s s_r;
  sdf_cic_s s_nxt;

  always_comb begin
    logic [W-1:0] x;
    logic [W-1:0] c1;
    logic [W-1:0] c2;
    x = {{(W-1){~bit_in}}, 1'b1};
    c1 = s_r.i3 - s_r.d1;
    c2 = c1 - s_r.d2;
    s_nxt = s_r;
    s_nxt.vld = 1'b0;
    s_nxt.dec_d = dec & smp;
    if (clr) begin
      s_nxt = '0;
    end else begin
      // Chained new values keep the window aligned to the last sample
      if (smp) begin
        s_nxt.i1 = s_r.i1 + x;
        s_nxt.i2 = s_r.i2 + s_nxt.i1;
        s_nxt.i3 = s_r.i3 + s_nxt.i2;
      end
      // Combs of length N give notches at every multiple of the rate
      if (s_r.dec_d) begin
        s_nxt.d1 = s_r.i3;
        s_nxt.d2 = c1;
        s_nxt.d3 = c2;
        s_nxt.y = c2 - s_r.d3;
        s_nxt.vld = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign y = s_r.y;
  assign y_vld = s_r.vld;
endmodule
`default_nettype wire

//--- sdf_div.sv
// Serial restoring divider used to normalise the sinc3 gain
`timescale 1ns/100ps
`default_nettype none
module sdf_div #(
  parameter int unsigned NW = sdf_pkg::NUM_W,
  parameter int unsigned DW = sdf_pkg::ACC_W
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [NW-1:0] num,
  input wire logic [DW-1:0] den,
  output logic [NW-1:0] quo,
  output logic busy,
  output logic done
);
  import sdf_pkg::*;

  localparam int unsigned CW = $clog2(NW);
  localparam logic [CW-1:0] CNT_LAST = CW'(NW - 1);

  typedef struct packed {
    logic busy;
    logic done;
    logic [CW-1:0] cnt;
    logic [DW:0] rem;
    logic [NW-1:0] sh;
  } sdf_div_s;

  sdf_div_s s_r;
  sdf_div_s s_nxt;

  always_comb begin
    logic [DW:0] r;
    logic qb;
    r = {s_r.rem[DW-1:0], s_r.sh[NW-1]};
    qb = 1'b0;
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (start && !s_r.busy) begin
      s_nxt.busy = 1'b1;
      s_nxt.cnt = '0;
      s_nxt.rem = '0;
      s_nxt.sh = num;
    end else if (s_r.busy) begin
      if (r >= {1'b0, den}) begin
        r = r - {1'b0, den};
        qb = 1'b1;
      end
      s_nxt.rem = r;
      s_nxt.sh = {s_r.sh[NW-2:0], qb};
      if (s_r.cnt == CNT_LAST) begin
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign quo = s_r.sh;
  assign busy = s_r.busy;
  assign done = s_r.done;
endmodule
`default_nettype wire

//--- sdf_top.sv
// Sinc3 decimation filter with its Wishbone register slave
`timescale 1ns/100ps
`default_nettype none
module sdf_top #(
  parameter int unsigned FSW = sdf_pkg::FSEL_W,
  parameter int unsigned AW = sdf_pkg::ACC_W,
  parameter int unsigned OW = sdf_pkg::OUT_W
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire sdf_pkg::sdf_wb_req_s wb_req,
  output sdf_pkg::sdf_wb_rsp_s wb_rsp,
  input wire logic mod_bit,
  output logic mod_strobe,
  input wire logic sync_pin_n,
  output logic [sdf_pkg::CHAN_W-1:0] chan_sel,
  output logic [OW-1:0] word_data,
  output logic word_valid,
  output logic settled
);
  import sdf_pkg::*;

  typedef struct packed {
    sdf_state_e st;
    logic [6:0] mdiv;
    logic [FSW-1:0] dcnt;
    logic [1:0] wcnt;
    logic [FSW-1:0] fsel;
    logic [CHAN_W-1:0] chan;
    logic ack;
    logic [31:0] rdat;
    logic [OW-1:0] word;
    logic vld;
    logic rdy;
    logic neg;
    logic pend;
  } sdf_main_s;

  sdf_main_s s_r;
  sdf_main_s s_nxt;
  logic [1:0] rsync_r;
  logic rst_n;
  logic clr;
  logic smp;
  logic dec;
  logic [FSW-1:0] nsel;
  logic [AW-1:0] ncube;
  logic [AW-1:0] cic_y;
  logic cic_vld;
  logic div_start;
  logic [NUM_W-1:0] div_num;
  logic [NUM_W-1:0] div_quo;
  logic div_busy;
  logic div_done;

  // Magnitude of a signed accumulator value
  function automatic logic [AW-1:0] mag(input logic [AW-1:0] v);
    logic [AW-1:0] r;
    r = v;
    if (v[AW-1]) begin
      r = ~v + 1'b1;
    end
    return r;
  endfunction

  // Reset is released through two flops; everything else uses the copy
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rsync_r <= 2'h0;
    end else begin
      rsync_r <= {rsync_r[0], 1'b1};
    end
  end
  assign rst_n = rsync_r[1];

  // A zero select word would stall the decimator, so it acts as one
  assign nsel = (s_r.fsel == '0) ? FSEL_ONE : s_r.fsel;

  // Gain of the three stages is N^3; the divider removes it
  assign ncube = AW'(nsel) * AW'(nsel) * AW'(nsel);

  assign clr = (s_r.st == SDF_ST_CLEAR);

  // Modulator sample point, once every 128 clocks
  assign smp = !clr && (s_r.mdiv == MOD_LAST);

  // Decimation at the N-th sample gives clock / (N * 128)
  assign dec = smp && (s_r.dcnt == (nsel - FSEL_ONE));

  // The first two words after a restart are dropped: the third window
  // is filled entirely with samples taken after the restart for every N; the second only for N of 1 or 2.
  assign div_start = cic_vld && ((s_r.st == SDF_ST_RUN) ||
    ((s_r.st == SDF_ST_FILL) && (s_r.wcnt == SETTLE_LAST)));

  // Full scale maps to 2^22 in a 24-bit word, leaving ample headroom
  assign div_num = {mag(cic_y), {FS_SHIFT{1'b0}}};

  sdf_cic #(
    .W(AW)
  ) u_cic (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(clr),
    .smp(smp),
    .bit_in(mod_bit),
    .dec(dec),
    .y(cic_y),
    .y_vld(cic_vld)
  );

  sdf_div #(
    .NW(NUM_W),
    .DW(AW)
  ) u_div (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(div_start),
    .num(div_num),
    .den(ncube),
    .quo(div_quo),
    .busy(div_busy),
    .done(div_done)
  );

  always_comb begin
    logic req;
    logic wr;
    logic rd_data;
    logic restart;
    logic [OW-1:0] q;
    logic [31:0] rd;
    req = wb_req.cyc && wb_req.stb;
    wr = req && s_r.ack && wb_req.we;
    rd_data = req && s_r.ack && !wb_req.we && (wb_req.adr == ADR_DATA);
    restart = 1'b0;
    q = {1'b0, div_quo[OW-2:0]};
    rd = 32'h0;
    s_nxt = s_r;
    s_nxt.vld = 1'b0;

    // Bus read mux; unmapped addresses read as zero
    case (wb_req.adr)
      ADR_CTRL: begin
        rd[CTRL_CHAN_LSB +: CHAN_W] = s_r.chan;
      end
      ADR_FILT: begin
        rd[FSW-1:0] = s_r.fsel;
      end
      ADR_STAT: begin
        rd[STAT_READY_BIT] = s_r.rdy;
        rd[STAT_SETTLED_BIT] = (s_r.st == SDF_ST_RUN);
        rd[STAT_BUSY_BIT] = s_r.pend || div_busy;
        rd[STAT_WCNT_LSB +: 2] = s_r.wcnt;
      end
      ADR_DATA: begin
        rd[OW-1:0] = s_r.word;
      end
      default: begin
        rd = 32'h0;
      end
    endcase

    // One wait state, ack for one cycle, then dropped
    if (req && !s_r.ack) begin
      s_nxt.ack = 1'b1;
      s_nxt.rdat = rd;
    end else begin
      s_nxt.ack = 1'b0;
    end

    // Writes take effect at the edge where the master sees ack
    if (wr) begin
      case (wb_req.adr)
        ADR_CTRL: begin
          if (wb_req.sel[0]) begin
            if (wb_req.dat[CTRL_RESTART_BIT]) begin
              restart = 1'b1;
            end
            if (wb_req.dat[CTRL_CHAN_LSB +: CHAN_W] != s_r.chan) begin
              restart = 1'b1;
            end
            s_nxt.chan = wb_req.dat[CTRL_CHAN_LSB +: CHAN_W];
          end
        end
        ADR_FILT: begin
          // Only the notch spacing moves; the stages are the same
          if (wb_req.sel[0]) begin
            s_nxt.fsel[7:0] = wb_req.dat[7:0];
            restart = 1'b1;
          end
          if (wb_req.sel[1]) begin
            s_nxt.fsel[FSW-1:8] = wb_req.dat[FSW-1:8];
            restart = 1'b1;
          end
        end
        default: begin
          restart = 1'b0;
        end
      endcase
    end

    // Reading the data word clears ready; a new word below wins
    if (rd_data) begin
      s_nxt.rdy = 1'b0;
    end

    // Modulator timebase and decimation counter
    s_nxt.mdiv = s_r.mdiv + 7'h01;
    if (smp) begin
      if (dec) begin
        s_nxt.dcnt = '0;
      end else begin
        s_nxt.dcnt = s_r.dcnt + FSEL_ONE;
      end
    end

    case (s_r.st)
      SDF_ST_CLEAR: begin
        s_nxt.st = SDF_ST_FILL;
        s_nxt.mdiv = 7'h00;
      end
      SDF_ST_FILL: begin
        if (cic_vld) begin
          if (s_r.wcnt == SETTLE_LAST) begin
            s_nxt.st = SDF_ST_RUN;
          end else begin
            s_nxt.wcnt = s_r.wcnt + 2'h1;
          end
        end
      end
      SDF_ST_RUN: begin
        // A free-running step settles as the three windows roll through
        s_nxt.st = SDF_ST_RUN;
      end
      default: begin
        s_nxt.st = SDF_ST_CLEAR;
      end
    endcase

    if (div_start) begin
      s_nxt.pend = 1'b1;
      s_nxt.neg = cic_y[AW-1];
    end

    // Normalised result, one strobe per settled period
    if (div_done && s_r.pend) begin
      s_nxt.pend = 1'b0;
      s_nxt.word = s_r.neg ? (~q + 1'b1) : q;
      s_nxt.vld = 1'b1;
      s_nxt.rdy = 1'b1;
    end

    // Sync pin held low keeps the filter cleared
    if (!sync_pin_n) begin
      restart = 1'b1;
    end

    // A restart drops a pending word; one finishing in the same cycle still loads word and ready, without its strobe
    if (restart) begin
      s_nxt.st = SDF_ST_CLEAR;
      s_nxt.mdiv = 7'h00;
      s_nxt.dcnt = '0;
      s_nxt.wcnt = 2'h0;
      s_nxt.pend = 1'b0;
      s_nxt.vld = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.fsel <= FSEL_RST;
      s_r.chan <= CHAN_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // The -3 dB point tracks the notch since the stage shape is fixed
  assign word_data = s_r.word;
  assign word_valid = s_r.vld;
  assign wb_rsp.ack = s_r.ack;
  assign wb_rsp.dat = s_r.rdat;
  assign mod_strobe = smp;
  assign chan_sel = s_r.chan;
  assign settled = (s_r.st == SDF_ST_RUN);
endmodule
`default_nettype wire

//--- sdf_top_properties.sv
// Port-level concurrent checks for the sinc3 decimation filter
`timescale 1ns/100ps
`default_nettype none
module sdf_top_chk #(
  parameter int unsigned OW = 24
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire sdf_pkg::sdf_wb_req_s wb_req,
  input wire sdf_pkg::sdf_wb_rsp_s wb_rsp,
  input wire logic mod_strobe,
  input wire logic sync_pin_n,
  input wire logic [sdf_pkg::CHAN_W-1:0] chan_sel,
  input wire logic [OW-1:0] word_data,
  input wire logic word_valid,
  input wire logic settled
);
  import sdf_pkg::*;
  // Saturating gap counters, so long idle spans never wrap into a false gap
  logic [7:0] sgap_r;
  logic [9:0] wgap_r;
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sgap_r <= 8'hff;
      wgap_r <= 10'h3ff;
    end else begin
      sgap_r <= mod_strobe ? 8'h00 : sgap_r + {7'h00, sgap_r != 8'hff};
      wgap_r <= word_valid ? 10'h000 : wgap_r + {9'h000, wgap_r != 10'h3ff};
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  chk_ack_one_wait: assert property ($rose(wb_req.stb) |=> wb_rsp.ack)
    else $error("ack did not follow the request by one cycle");
  chk_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack)
    else $error("ack stood for more than one cycle");
  chk_strobe_gap: assert property (mod_strobe |-> sgap_r >= 8'h7f)
    else $error("modulator samples closer than 128 clocks");
  chk_word_gap: assert property (word_valid |-> wgap_r >= 10'h07f)
    else $error("output words closer than 128 clocks");
  chk_valid_pulse: assert property (word_valid |=> !word_valid)
    else $error("word strobe longer than one cycle");
  chk_word_hold: assert property (!word_valid |-> $stable(word_data))
    else $error("word changed without its strobe");
  chk_word_settled: assert property (word_valid |-> ##[0:1] settled)
    else $error("word presented while not settled");
  chk_sync_clear: assert property (!sync_pin_n [*6] |->
    !mod_strobe && !word_valid && !settled)
    else $error("filter running while sync held low");
  chk_chan_restart: assert property ($changed(chan_sel) |->
    ##[0:2] !settled)
    else $error("channel change did not restart the filter");
endmodule
bind sdf_top sdf_top_chk #(.OW(OW)) i_sdf_top_chk (
  .clk_sys(clk_sys),
  .arst_n(arst_n),
  .wb_req(wb_req),
  .wb_rsp(wb_rsp),
  .mod_strobe(mod_strobe),
  .sync_pin_n(sync_pin_n),
  .chan_sel(chan_sel),
  .word_data(word_data),
  .word_valid(word_valid),
  .settled(settled)
);
`default_nettype wire

//--- sdf_mod_src.sv
// Modulator bitstream source model
`timescale 1ns/100ps
`default_nettype none
module sdf_mod_src (
  input wire logic mod_strobe,
  input wire logic level,
  output logic mod_bit
);
  // Valid only in the sample cycle; inverted elsewhere to expose late sampling
  assign mod_bit = mod_strobe ? level : ~level;
endmodule
`default_nettype wire

//--- tb_sdf_top.sv
// Self-checking bench for the sinc3 decimation filter
`timescale 1ns/100ps
`default_nettype none
module tb_sdf_top;
  import sdf_pkg::*;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic sync_pin_n = 1'b1;
  logic level = 1'b1;
  sdf_wb_req_s wb_req = '0;
  sdf_wb_rsp_s wb_rsp;
  logic mod_bit;
  logic mod_strobe;
  logic [2:0] chan_sel;
  logic [23:0] word_data;
  logic word_valid;
  logic settled;
  logic [31:0] q;
  int err_total = 0;
  int compares = 0;
  int cyc_cnt = 0;
  always #5 clk_sys = ~clk_sys;
  sdf_top i_sdf_top (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .wb_req(wb_req),
    .wb_rsp(wb_rsp),
    .mod_bit(mod_bit),
    .mod_strobe(mod_strobe),
    .sync_pin_n(sync_pin_n),
    .chan_sel(chan_sel),
    .word_data(word_data),
    .word_valid(word_valid),
    .settled(settled)
  );
  sdf_mod_src i_sdf_mod_src (
    .mod_strobe(mod_strobe),
    .level(level),
    .mod_bit(mod_bit)
  );
  task wrap_up;
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Whole run needs about 10000 cycles
  always @(posedge clk_sys) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 40000) begin
      err_total++;
      wrap_up();
    end
  end
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task cmp_rng(input int got, input int lo, input int hi);
    compares++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    do @(posedge clk_sys); while (wb_rsp.ack !== 1'b1);
    q = wb_rsp.dat;
    wb_req <= '0;
  endtask
  task wait_word(output int dt);
    int t0;
    t0 = cyc_cnt;
    do @(posedge clk_sys); while (word_valid !== 1'b1);
    dt = cyc_cnt - t0;
  endtask
  initial begin
    int dt;
    int nn;
    repeat (4) @(posedge clk_sys);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    wb(1'b0, ADR_FILT, 32'h0);
    cmp(q, {20'h0, FSEL_RST});
    wb(1'b1, 8'h20, 32'hffffffff);
    wb(1'b0, 8'h20, 32'h0);
    cmp(q, 32'h0);
    // Upper select bits come through the second byte lane
    wb(1'b1, ADR_FILT, 32'hfffffa5c);
    wb(1'b0, ADR_FILT, 32'h0);
    cmp(q, 32'ha5c);
    // N of 0 behaves as 1; alternate polarity so each N sees a new level
    for (int n = 0; n <= 3; n++) begin
      nn = (n == 0) ? 1 : n;
      level <= n[0];
      wb(1'b1, ADR_FILT, n);
      wait_word(dt);
      cmp_rng(dt, 384 * nn, 384 * nn + 200);
      cmp({8'h0, word_data}, n[0] ? 32'h400000 : 32'hc00000);
      wait_word(dt);
      cmp_rng(dt, 128 * nn, 128 * nn);
      cmp({31'h0, settled}, 32'h1);
    end
    repeat (50) @(posedge clk_sys);
    level <= 1'b0;
    // Step lands before the next sample, so the taps 1,3,6,7,6,3,1 of N=3
    // give 7/27 and then -25/27 of full scale on the way down
    wait_word(dt);
    cmp({8'h0, word_data}, 32'h1097b4);
    wait_word(dt);
    cmp({8'h0, word_data}, 32'hc4bda2);
    repeat (2) wait_word(dt);
    cmp({8'h0, word_data}, 32'hc00000);
    wb(1'b0, ADR_STAT, 32'h0);
    cmp(q & 32'h1, 32'h1);
    wb(1'b0, ADR_DATA, 32'h0);
    cmp(q, 32'hc00000);
    wb(1'b0, ADR_STAT, 32'h0);
    cmp(q & 32'h1, 32'h0);
    wb(1'b1, ADR_CTRL, 32'h30);
    // The channel register updates at the ack edge; look one edge later
    @(posedge clk_sys);
    cmp({29'h0, chan_sel}, 32'h3);
    wait_word(dt);
    cmp_rng(dt, 1152, 1352);
    wb(1'b1, ADR_CTRL, 32'h31);
    wait_word(dt);
    cmp_rng(dt, 1152, 1352);
    wb(1'b0, ADR_CTRL, 32'h0);
    cmp(q, 32'h30);
    sync_pin_n <= 1'b0;
    repeat (600) @(posedge clk_sys);
    sync_pin_n <= 1'b1;
    wait_word(dt);
    cmp_rng(dt, 1152, 1352);
    cmp({8'h0, word_data}, 32'hc00000);
    wrap_up();
  end
endmodule
`default_nettype wire
